// ==== hw/fpc_top.sv ====
// span and band configuration for the three fan drive outputs, duty ramp for remote 1 only
`timescale 1ns/1ps
// ----------------------------------------------------------------
// How it works
// [R1] once the global lock is set, writes to these registers are ignored
// [R2] each span/frequency register powers up at 0xc4
// [R3] bits 2:0 choose the low band rate, 11.0 Hz up to 88.2 Hz
// [R4] low band rate is applied only in low band, ignored in high band
// [R5] bit 3 picks band: 1 high frequency, 0 low frequency
// [R6] bits 7:4 set the temperature span of automatic duty control
// [R7] span codes decode 2 to 80 degrees Celsius, 1100 is 32
// [R8] remote 1 duty steps toward its target at the ramp rate, never jumps
// [R9] ramp codes give 1,2,3,4,8,12,24,48 duty steps per slot
// [R10] 0x5f remote 1 channel, 0x60 local channel, 0x61 remote 2 channel
// [R11] time slots come from a prescaled tick, short or long per the slow select, matching the ramp times
// ----------------------------------------------------------------
module fpc_top #(
    parameter int SLOT_FAST_CYC = fpc_pkg::FPC_SLOT_FAST_CYC,
    parameter int SLOT_SLOW_CYC = fpc_pkg::FPC_SLOT_SLOW_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port from the management bus engine
    input wire logic wr_en_i,
    input wire logic [7:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [7:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    // global configuration lock and slow ramp select
    input wire logic lock_i,
    input wire logic slow_ramp_i,
    // remote 1 duty request and ramped result
    input wire logic [7:0] target_duty_i,
    output logic [7:0] duty_ramped_o,
    // per-channel drive settings, index 0 remote 1, 1 local, 2 remote 2
    output fpc_pkg::fpc_drive_t [2:0] fan_drive_output_o
);
    import fpc_pkg::*;

    fpc_chan_cfg_t [2:0] chan_cfg;
    logic [7:0] acoustic_ramp_config;
    logic [FPC_SLOT_W-1:0] slot_cnt;
    logic [FPC_SLOT_W-1:0] slot_len;
    logic slot_tick;
    logic [7:0] step;
    logic [7:0] next_duty;

    // ----------------------------------------------------------------
    // span decode
    // ----------------------------------------------------------------
    // hundredths of a degree so fractional spans stay exact enough
    function automatic logic [15:0] span_centi(input logic [3:0] code);
        logic [15:0] v;
        v = 16'h0000;
        case (code)
            4'h0: v = 16'd200;
            4'h1: v = 16'd250;
            4'h2: v = 16'd333;
            4'h3: v = 16'd400;
            4'h4: v = 16'd500;
            4'h5: v = 16'd667;
            4'h6: v = 16'd800;
            4'h7: v = 16'd1000;
            4'h8: v = 16'd1333;
            4'h9: v = 16'd1600;
            4'ha: v = 16'd2000;
            4'hb: v = 16'd2667;
            4'hc: v = 16'd3200;
            4'hd: v = 16'd4000;
            4'he: v = 16'd5333;
            default: v = 16'd8000;
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // lock blocks every write; stored values stay as they were
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            chan_cfg <= {3{FPC_SPAN_LOW_BAND_RATE_SELECT_RST}}; // R2
            acoustic_ramp_config <= FPC_ACOUSTIC_RAMP_RST;
        end else if (wr_en_i && !lock_i) begin // R1
            case (wr_addr_i)
                FPC_REMOTE1_SPAN_LOW_BAND_RATE_SELECT_OFS: chan_cfg[0] <= wr_data_i; // R10
                FPC_LOCAL_SPAN_LOW_BAND_RATE_SELECT_OFS: chan_cfg[1] <= wr_data_i; // R10
                FPC_REMOTE2_SPAN_LOW_BAND_RATE_SELECT_OFS: chan_cfg[2] <= wr_data_i; // R10
                FPC_ACOUSTIC_RAMP_CONFIG_OFS: acoustic_ramp_config <= wr_data_i;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    // unmapped addresses read as zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= 8'h00;
        end else begin
            case (rd_addr_i)
                FPC_REMOTE1_SPAN_LOW_BAND_RATE_SELECT_OFS: rd_data_o <= chan_cfg[0];
                FPC_LOCAL_SPAN_LOW_BAND_RATE_SELECT_OFS: rd_data_o <= chan_cfg[1];
                FPC_REMOTE2_SPAN_LOW_BAND_RATE_SELECT_OFS: rd_data_o <= chan_cfg[2];
                FPC_ACOUSTIC_RAMP_CONFIG_OFS: rd_data_o <= acoustic_ramp_config;
                default: rd_data_o <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // per-channel drive settings
    // ----------------------------------------------------------------
    // rate forced to zero in high band so the generator cannot act on it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fan_drive_output_o <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                fan_drive_output_o[i].hf_en <= chan_cfg[i].band; // R5
                fan_drive_output_o[i].lf_rate <= chan_cfg[i].band ? 3'h0 : chan_cfg[i].rate; // R3 R4
                fan_drive_output_o[i].span_centi <= span_centi(chan_cfg[i].span); // R6 R7
            end
        end
    end

    // ----------------------------------------------------------------
    // ramp time slot prescaler
    // ----------------------------------------------------------------
    // one slot is full-scale time over 255 steps; the slow select stretches it
    // the slow select is read live, so a switch to the short slot may end the current slot early
    assign slot_len = slow_ramp_i ? FPC_SLOT_W'(SLOT_SLOW_CYC) : FPC_SLOT_W'(SLOT_FAST_CYC);
    assign slot_tick = (slot_cnt >= slot_len - FPC_SLOT_W'(1)); // R11

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            slot_cnt <= '0;
        end else if (slot_tick) begin
            slot_cnt <= '0; // R11
        end else begin
            slot_cnt <= slot_cnt + FPC_SLOT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // remote 1 duty ramp
    // ----------------------------------------------------------------
    // step size per slot from the ramp code
    always_comb begin
        case (acoustic_ramp_config[FPC_RAMP_LSB +: 3])
            3'h0: step = 8'd1; // R9
            3'h1: step = 8'd2;
            3'h2: step = 8'd3;
            3'h3: step = 8'd4;
            3'h4: step = 8'd8;
            3'h5: step = 8'd12;
            3'h6: step = 8'd24;
            default: step = 8'd48;
        endcase
    end

    // clamp the last step so the target is reached, not overshot
    always_comb begin
        next_duty = duty_ramped_o;
        if (target_duty_i > duty_ramped_o) begin
            next_duty = (target_duty_i - duty_ramped_o > step) ? duty_ramped_o + step : target_duty_i;
        end else if (target_duty_i < duty_ramped_o) begin
            next_duty = (duty_ramped_o - target_duty_i > step) ? duty_ramped_o - step : target_duty_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            duty_ramped_o <= 8'h00;
        end else if (slot_tick) begin
            duty_ramped_o <= next_duty; // R8
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic seen_wr;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            seen_wr <= 1'b0;
        end else if (wr_en_i) begin
            seen_wr <= 1'b1;
        end
    end

    property p_lock_holds;
        lock_i && wr_en_i |=> $stable(chan_cfg) && $stable(acoustic_ramp_config);
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("write took effect while locked"); // R1

    property p_reset_value;
        !seen_wr |-> chan_cfg[0] == FPC_SPAN_LOW_BAND_RATE_SELECT_RST && chan_cfg[1] == FPC_SPAN_LOW_BAND_RATE_SELECT_RST
            && chan_cfg[2] == FPC_SPAN_LOW_BAND_RATE_SELECT_RST;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("span register lost reset value"); // R2

    property p_local_addr;
        wr_en_i && !lock_i && wr_addr_i == FPC_LOCAL_SPAN_LOW_BAND_RATE_SELECT_OFS |=> chan_cfg[1] == $past(wr_data_i) ##1
            fan_drive_output_o[1].hf_en == $past(chan_cfg[1].band);
    endproperty
    a_local_addr: assert property (p_local_addr) else $error("local channel write misrouted"); // R10

    property p_remote1_addr;
        wr_en_i && !lock_i && wr_addr_i == FPC_REMOTE1_SPAN_LOW_BAND_RATE_SELECT_OFS |=> chan_cfg[0] == $past(wr_data_i);
    endproperty
    a_remote1_addr: assert property (p_remote1_addr) else $error("remote 1 channel write misrouted"); // R10

    property p_remote2_addr;
        wr_en_i && !lock_i && wr_addr_i == FPC_REMOTE2_SPAN_LOW_BAND_RATE_SELECT_OFS |=> chan_cfg[2] == $past(wr_data_i);
    endproperty
    a_remote2_addr: assert property (p_remote2_addr) else $error("remote 2 channel write misrouted"); // R10

    property p_read_local;
        rd_addr_i == FPC_LOCAL_SPAN_LOW_BAND_RATE_SELECT_OFS |=> rd_data_o == $past(chan_cfg[1]);
    endproperty
    a_read_local: assert property (p_read_local) else $error("local channel read misrouted"); // R10

    property p_unmapped_read;
        rd_addr_i < FPC_REMOTE1_SPAN_LOW_BAND_RATE_SELECT_OFS || rd_addr_i > FPC_ACOUSTIC_RAMP_CONFIG_OFS
            |=> rd_data_o == 8'h00;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // R10

    property p_lf_rate;
        !chan_cfg[0].band |=> fan_drive_output_o[0].lf_rate == $past(chan_cfg[0].rate);
    endproperty
    a_lf_rate: assert property (p_lf_rate) else $error("low band rate not passed"); // R3

    property p_hf_ignores_rate;
        chan_cfg[2].band |=> fan_drive_output_o[2].hf_en && fan_drive_output_o[2].lf_rate == 3'h0;
    endproperty
    a_hf_ignores_rate: assert property (p_hf_ignores_rate) else $error("rate used in high band"); // R4 R5

    property p_span_default;
        chan_cfg[0].span == 4'hc ##1 chan_cfg[0].span == 4'hc |-> fan_drive_output_o[0].span_centi == 16'd3200;
    endproperty
    a_span_default: assert property (p_span_default) else $error("span 1100 not 32 degrees"); // R6 R7

    property p_moves_on_tick;
        $changed(duty_ramped_o) |-> $past(slot_tick);
    endproperty
    a_moves_on_tick: assert property (p_moves_on_tick) else $error("duty moved between slots"); // R8

    property p_step_bound;
        slot_tick |=> (duty_ramped_o >= $past(duty_ramped_o) ? duty_ramped_o - $past(duty_ramped_o)
            : $past(duty_ramped_o) - duty_ramped_o) <= $past(step);
    endproperty
    a_step_bound: assert property (p_step_bound) else $error("duty step above ramp rate"); // R9

    property p_top_code_step;
        slot_tick && acoustic_ramp_config[2:0] == 3'h7 && target_duty_i >= duty_ramped_o + 9'd48
            |=> duty_ramped_o == $past(duty_ramped_o) + 8'd48;
    endproperty
    a_top_code_step: assert property (p_top_code_step) else $error("code 111 not 48 per slot"); // R9

    // a slot step lands between the old duty and the target, never past it
    property p_ramp_up_bound;
        slot_tick && target_duty_i >= duty_ramped_o
            |=> duty_ramped_o >= $past(duty_ramped_o) && duty_ramped_o <= $past(target_duty_i);
    endproperty
    a_ramp_up_bound: assert property (p_ramp_up_bound) else $error("duty ramp overshot going up"); // R8

    property p_ramp_down_bound;
        slot_tick && target_duty_i <= duty_ramped_o
            |=> duty_ramped_o <= $past(duty_ramped_o) && duty_ramped_o >= $past(target_duty_i);
    endproperty
    a_ramp_down_bound: assert property (p_ramp_down_bound) else $error("duty ramp overshot going down"); // R8

    // a live switch to the short slot may leave the count above the new length for one cycle
    property p_slot_bound;
        slot_cnt < slot_len || $changed(slow_ramp_i);
    endproperty
    a_slot_bound: assert property (p_slot_bound) else $error("slot counter overran"); // R11

    property p_slot_length;
        slot_tick && $stable(slow_ramp_i) |-> slot_cnt == (slow_ramp_i ? FPC_SLOT_W'(SLOT_SLOW_CYC - 1)
            : FPC_SLOT_W'(SLOT_FAST_CYC - 1));
    endproperty
    a_slot_length: assert property (p_slot_length) else $error("slot length wrong"); // R11

    property p_slot_wrap;
        slot_tick |=> slot_cnt == '0;
    endproperty
    a_slot_wrap: assert property (p_slot_wrap) else $error("slot counter did not wrap"); // R11

    property p_band_follows;
        1'b1 |=> fan_drive_output_o[0].hf_en == $past(chan_cfg[0].band)
            && fan_drive_output_o[1].hf_en == $past(chan_cfg[1].band)
            && fan_drive_output_o[2].hf_en == $past(chan_cfg[2].band);
    endproperty
    a_band_follows: assert property (p_band_follows) else $error("band select not passed"); // R5

    c_locked_write: cover property (lock_i && wr_en_i && wr_addr_i == FPC_REMOTE1_SPAN_LOW_BAND_RATE_SELECT_OFS);
    c_ramp_up: cover property (slot_tick && target_duty_i > duty_ramped_o);
    c_ramp_down: cover property (slot_tick && target_duty_i < duty_ramped_o);
    c_high_band: cover property (fan_drive_output_o[1].hf_en);
    c_slow_slot: cover property (slot_tick && slow_ramp_i);
endmodule

// ==== hw/fpc_pkg.sv ====
// constants and carrier types for the fan drive span, band and ramp configuration block
package fpc_pkg;
    // register offsets on the management register port
    localparam logic [7:0] FPC_REMOTE1_SPAN_LOW_BAND_RATE_SELECT_OFS = 8'h5f;
    localparam logic [7:0] FPC_LOCAL_SPAN_LOW_BAND_RATE_SELECT_OFS = 8'h60;
    localparam logic [7:0] FPC_REMOTE2_SPAN_LOW_BAND_RATE_SELECT_OFS = 8'h61;
    localparam logic [7:0] FPC_ACOUSTIC_RAMP_CONFIG_OFS = 8'h62;
    // reset values
    localparam logic [7:0] FPC_SPAN_LOW_BAND_RATE_SELECT_RST = 8'hc4;
    localparam logic [7:0] FPC_ACOUSTIC_RAMP_RST = 8'h00;
    // field positions of the span/frequency register
    localparam int FPC_RATE_LSB = 0;
    localparam int FPC_BAND_BIT = 3;
    localparam int FPC_SPAN_LSB = 4;
    // field position of the ramp rate in the acoustic register
    localparam int FPC_RAMP_LSB = 0;
    // ramp time slot lengths, in microseconds, and the clock rate
    localparam int FPC_CLK_MHZ = 10;
    localparam int FPC_SLOT_FAST_US = 147000;
    localparam int FPC_SLOT_SLOW_US = 204700;
    localparam int FPC_SLOT_FAST_CYC = FPC_SLOT_FAST_US * FPC_CLK_MHZ;
    localparam int FPC_SLOT_SLOW_CYC = FPC_SLOT_SLOW_US * FPC_CLK_MHZ;
    localparam int FPC_SLOT_W = 21;

    // one span/frequency register as stored
    typedef struct packed {
        logic [3:0] span;
        logic band;
        logic [2:0] rate;
    } fpc_chan_cfg_t;

    // what a channel's drive generator is told
    typedef struct packed {
        logic hf_en;
        logic [2:0] lf_rate;
        logic [15:0] span_centi;
    } fpc_drive_t;
endpackage

// ==== bench/fpc_fan_model.sv ====
// fan side model: watches the drive settings and the ramped duty it is fed
`timescale 1ns/1ps
module fpc_fan_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // what the fans are driven with
    input fpc_pkg::fpc_drive_t [2:0] drive_i,
    input wire logic [7:0] duty_i,
    // sticky flag: a duty jump bigger than any ramp step
    output logic jump_o,
    // sticky flag: a high band channel handed a low band rate
    output logic rate_leak_o
);
    import fpc_pkg::*;
    logic [7:0] last_duty;
    // a real fan only hears the duty; a large jump is audible, so remember it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_duty <= 8'h00;
            jump_o <= 1'b0;
            rate_leak_o <= 1'b0;
        end else begin
            last_duty <= duty_i;
            if ((duty_i > last_duty ? duty_i - last_duty : last_duty - duty_i) > 8'h30) begin
                jump_o <= 1'b1;
            end
            // a high band fan drive has no use for the low band rate
            for (int i = 0; i < 3; i++) begin
                if (drive_i[i].hf_en && drive_i[i].lf_rate != 3'h0) begin
                    rate_leak_o <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the span, band and ramp configuration block
`timescale 1ns/1ps
module tb;
    import fpc_pkg::*;
    localparam int FAST = 4;
    localparam int SLOW = 6;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wr_en_i = 1'b0;
    logic lock_i = 1'b0;
    logic slow_ramp_i = 1'b0;
    logic [7:0] wr_addr_i = 8'h00, wr_data_i = 8'h00, rd_addr_i = 8'h00, target_duty_i = 8'h00;
    logic [7:0] rd_data_o, duty_ramped_o;
    fpc_drive_t [2:0] fan_drive_output_o;
    logic jump_seen;
    logic rate_leak;
    int miscompares = 0, num_checks = 0, cycles = 0;
    logic [7:0] shadow [4];
    logic [15:0] span_tab [16] = '{16'd200, 16'd250, 16'd333, 16'd400, 16'd500, 16'd667, 16'd800, 16'd1000,
        16'd1333, 16'd1600, 16'd2000, 16'd2667, 16'd3200, 16'd4000, 16'd5333, 16'd8000};
    int step_tab [8] = '{1, 2, 3, 4, 8, 12, 24, 48};

    always #50 clk_i = ~clk_i;

    fpc_top #(.SLOT_FAST_CYC(FAST), .SLOT_SLOW_CYC(SLOW)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i),
        .rd_data_o(rd_data_o), .lock_i(lock_i), .slow_ramp_i(slow_ramp_i), .target_duty_i(target_duty_i),
        .duty_ramped_o(duty_ramped_o), .fan_drive_output_o(fan_drive_output_o));
    fpc_fan_model fans (.clk_i(clk_i), .rst_i(rst_i), .drive_i(fan_drive_output_o), .duty_i(duty_ramped_o),
        .jump_o(jump_seen), .rate_leak_o(rate_leak));

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // the shadow copy only follows writes the block should accept
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr_en_i = 1'b1;
        wr_addr_i = a;
        wr_data_i = d;
        @(negedge clk_i);
        wr_en_i = 1'b0;
        if (!lock_i && a >= 8'h5f && a <= 8'h62) shadow[a - 8'h5f] = d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        rd_addr_i = a;
        @(negedge clk_i);
        d = rd_data_o;
    endtask

    function automatic fpc_drive_t drv_exp(input logic [7:0] r);
        fpc_drive_t e;
        e.hf_en = r[3];
        e.lf_rate = r[3] ? 3'h0 : r[2:0];
        e.span_centi = span_tab[r[7:4]];
        return e;
    endfunction

    // slot spacing is only checked between moves, since the slot phase is free running
    task automatic ramp(input logic [2:0] code, input logic slow, input logic [7:0] tgt);
        logic [7:0] prev;
        int since, moves, step, gap;
        step = step_tab[code];
        wr(8'h62, {5'h00, code});
        slow_ramp_i = slow;
        target_duty_i = tgt;
        prev = duty_ramped_o;
        since = 0;
        moves = 0;
        for (int n = 0; n < 1700 && duty_ramped_o !== tgt; n++) begin
            @(negedge clk_i);
            since++;
            if (duty_ramped_o !== prev) begin
                gap = (tgt > prev) ? tgt - prev : prev - tgt;
                if (gap > step) gap = step;
                chk("ramp step", duty_ramped_o, (tgt > prev) ? prev + gap : prev - gap);
                if (moves > 0) chk("slot length", since, slow ? SLOW : FAST);
                moves++;
                since = 0;
                prev = duty_ramped_o;
            end
        end
        chk("ramp end", duty_ramped_o, tgt);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] v;
        int ch;
        void'($urandom(32'he201c3c9));
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        @(negedge clk_i);
        for (int i = 0; i < 3; i++) shadow[i] = 8'hc4;
        shadow[3] = 8'h00;
        for (int i = 0; i < 4; i++) begin
            rd(8'h5f + i[7:0], v);
            chk("reset register", v, shadow[i]);
        end
        rd(8'h70, v);
        chk("unmapped read", v, 8'h00);
        for (int i = 0; i < 3; i++) chk("reset drive", fan_drive_output_o[i], drv_exp(8'hc4));
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            ch = $urandom_range(2);
            wr(8'h5f + ch[7:0], {i[3:0], i[4], i[2:0]});
            @(negedge clk_i);
            chk("drive decode", fan_drive_output_o[ch], drv_exp(shadow[ch]));
            rd(8'h5f + ch[7:0], v);
            chk("read back", v, shadow[ch]);
        end
        $display("test decode done");
        lock_i = 1'b1;
        for (int i = 0; i < 4; i++) wr(8'h5f + i[7:0], 8'($urandom));
        for (int i = 0; i < 4; i++) begin
            rd(8'h5f + i[7:0], v);
            chk("locked register", v, shadow[i]);
        end
        for (int i = 0; i < 3; i++) chk("locked drive", fan_drive_output_o[i], drv_exp(shadow[i]));
        lock_i = 1'b0;
        $display("test lock done");
        for (int c = 0; c < 8; c++) ramp(c[2:0], 1'b0, c[0] ? 8'h00 : 8'hf0 | 8'($urandom_range(15)));
        ramp(3'h7, 1'b1, 8'hc0);
        ramp(3'h2, 1'b1, 8'hff);
        ramp(3'h6, 1'b1, 8'($urandom_range(255)));
        chk("duty jump at fan", jump_seen, 1'b0);
        chk("low band rate at high band fan", rate_leak, 1'b0);
        $display("test ramp done");
        final_report();
    end

    // hang guard well above the longest ramp sequence
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            final_report();
        end
    end
endmodule
